/* logic/logic_tile_storage_pair.sv */
// top of the logic tile storage pair with its ahb-lite register slave
//
// Functional notes
// [RULE1] two edge-triggered elements share trigger and enable
// [RULE2] capture comb result or other data, routable
// [RULE3] per element trigger inversion selects active edge
// [RULE4] enable high updates, enable low holds
// [RULE5] unconnected enable counts as always asserted
// [RULE6] no enable inversion inside the tile
// [RULE7] either element may have permanently active enable
// [RULE8] force, set/reset or power-up load initial value
// [RULE9] latch passes data while trigger low
// [RULE10] initial value per element, reset by default
`timescale 1ns/1ns
`default_nettype none

module logic_tile_storage_pair
    import tile_storage_pkg::*;
#(
    parameter int NUM_ELEMENTS = ELEMENT_COUNT
)
(
    // clock and synchronous reset
    input wire logic ref_clk,
    input wire logic reset,
    // ahb-lite slave port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // shared tile controls from the routing fabric
    input wire logic trigger,
    input wire logic gateEnable,
    input wire logic forceInit,
    input wire logic globalForce,
    // per element data from the routing fabric
    input wire logic [NUM_ELEMENTS-1:0] combData,
    input wire logic [NUM_ELEMENTS-1:0] otherData,
    // per element outputs to the interconnect
    output logic [NUM_ELEMENTS-1:0] storedOut,
    output logic [NUM_ELEMENTS-1:0] tileOut
);

    // complete state of the top: bus slave and registered tile outputs
    typedef struct packed {
        logic wrPending;              // write data phase follows
        logic [DECODE_BITS-1:0] wrAddr; // decoded address of the pending write
        logic [31:0] config_;         // configuration register
        logic [31:0] rdData;          // read data of the current data phase
        logic [NUM_ELEMENTS-1:0] tileOutReg; // combinational or stored value per element
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    // shared controls bundled for the elements
    tile_ctrl_t ctrl;
    // per element configuration split out of the register
    cell_cfg_t cellCfg [NUM_ELEMENTS];
    // stored value of each element
    logic [NUM_ELEMENTS-1:0] stored;

    // address phase taken this cycle
    logic addrTaken;
    // decoded address of the current address phase
    logic [DECODE_BITS-1:0] curAddr;
    // config value as the current read must see it
    logic [31:0] configView;
    // status word built from element state
    logic [31:0] statusWord;

    // the shared pins go to both elements unchanged; no enable inversion here
    always_comb begin
        ctrl.trigger = trigger; // [RULE1]
        ctrl.gateEnable = gateEnable; // [RULE6]
        ctrl.forceInit = forceInit;
        ctrl.globalForce = globalForce;
    end

    // slice each element's config field out of the register
    always_comb begin
        for (int i = 0; i < NUM_ELEMENTS; i++) begin
            cellCfg[i] = cell_cfg_t'(state.config_[i*FIELD_STRIDE +: CFG_FIELD_WIDTH]);
        end
    end

    // one storage element per tile position
    for (genvar g = 0; g < NUM_ELEMENTS; g++) begin : gen_cell
        // data offered to this element
        cell_data_t cellData;
        assign cellData.combData = combData[g];
        assign cellData.otherData = otherData[g];

        storage_cell u_cell (
            .ref_clk(ref_clk),
            .reset(reset),
            .cfg(cellCfg[g]),
            .ctrl(ctrl),
            .din(cellData),
            .stored(stored[g])
        );
    end

    // address phase decode; only a nonseq on a ready bus is a transfer
    always_comb begin
        addrTaken = hsel && hready && (htrans == HTRANS_NONSEQ);
        curAddr = haddr[DECODE_BITS-1:0];
    end

    // a read right after a write to config must see the new value, masked like the register
    always_comb begin
        if (state.wrPending && (state.wrAddr == CONFIG_OFFSET[DECODE_BITS-1:0])) begin
            // only the defined option bits of each element show through
            configView = 32'h0000_0000;
            for (int i = 0; i < NUM_ELEMENTS; i++) begin
                configView[i*FIELD_STRIDE +: CFG_FIELD_WIDTH] =
                    hwdata[i*FIELD_STRIDE +: CFG_FIELD_WIDTH];
            end
        end else begin
            configView = state.config_;
        end
    end

    // status shows each element's stored value and its tile output
    always_comb begin
        statusWord = 32'h0000_0000;
        for (int i = 0; i < NUM_ELEMENTS; i++) begin
            statusWord[i*FIELD_STRIDE + STAT_STORED_POS] = stored[i];
            statusWord[i*FIELD_STRIDE + STAT_TILE_OUT_POS] = state.tileOutReg[i];
        end
    end

    // next state of the slave and of the registered outputs
    always_comb begin
        next_state = state;

        // write data phase: store the word into the addressed register
        if (state.wrPending) begin
            if (state.wrAddr == CONFIG_OFFSET[DECODE_BITS-1:0]) begin
                // only the defined option bits of each element are kept
                next_state.config_ = 32'h0000_0000;
                for (int i = 0; i < NUM_ELEMENTS; i++) begin
                    next_state.config_[i*FIELD_STRIDE +: CFG_FIELD_WIDTH] =
                        hwdata[i*FIELD_STRIDE +: CFG_FIELD_WIDTH];
                end
            end
            // status and unmapped addresses ignore writes
        end

        // new address phase: latch write intent, prepare read data
        next_state.wrPending = addrTaken && hwrite;
        next_state.wrAddr = curAddr;
        if (addrTaken && !hwrite) begin
            if (curAddr == CONFIG_OFFSET[DECODE_BITS-1:0]) begin
                next_state.rdData = configView;
            end else if (curAddr == STATUS_OFFSET[DECODE_BITS-1:0]) begin
                next_state.rdData = statusWord;
            end else begin
                // unmapped address reads as zero
                next_state.rdData = 32'h0000_0000;
            end
        end else begin
            next_state.rdData = 32'h0000_0000;
        end

        // route each element's stored value or the comb result to the interconnect
        for (int i = 0; i < NUM_ELEMENTS; i++) begin
            next_state.tileOutReg[i] = cellCfg[i].routeStored ? stored[i] : combData[i]; // [RULE2]
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state.wrPending <= 1'b0;
            state.wrAddr <= '0;
            state.config_ <= CONFIG_RESET; // [RULE10]
            state.rdData <= 32'h0000_0000;
            state.tileOutReg <= '0;
        end else begin
            state <= next_state;
        end
    end

    // bus answers: never waits, always okay
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // outputs straight from flip-flops
    assign hrdata = state.rdData;
    assign storedOut = stored; // [RULE2]
    assign tileOut = state.tileOutReg;

endmodule : logic_tile_storage_pair

`default_nettype wire

/* logic/tile_storage_pkg.sv */
// package: register map, field layout and carrier types of the logic tile storage pair
package tile_storage_pkg;

    // number of storage elements in one logic tile
    localparam int ELEMENT_COUNT = 2;

    // register byte offsets on the bus
    localparam logic [31:0] CONFIG_OFFSET = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

    // address bits that take part in the register decode
    localparam int DECODE_BITS = 8;

    // bit position of each element's field in config and status
    localparam int FIELD_STRIDE = 8;

    // field positions inside one element's config byte
    localparam int CFG_INVERT_POS = 0;
    localparam int CFG_ENABLE_TIED_POS = 1;
    localparam int CFG_INIT_SET_POS = 2;
    localparam int CFG_LATCH_POS = 3;
    localparam int CFG_CAPTURE_OTHER_POS = 4;
    localparam int CFG_ROUTE_STORED_POS = 5;
    localparam int CFG_FIELD_WIDTH = 6;

    // status field positions inside one element's byte
    localparam int STAT_STORED_POS = 0;
    localparam int STAT_TILE_OUT_POS = 1;

    // reset value of the config register: reset init, honoured enable, flip-flop, rising edge
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

    // ahb transfer type and response codes used by the slave
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // per element configuration, one bit per option
    typedef struct packed {
        logic routeStored;   // tile output shows the stored value instead of the comb result
        logic captureOther;  // element captures the other incoming data, not the comb result
        logic latchMode;     // level-sensitive latch instead of edge-triggered flip-flop
        logic initSet;       // initial value is set (1) rather than reset (0)
        logic enableTied;    // shared enable treated as unconnected, so always active
        logic invertTrigger; // element acts on the falling edge / opposite level
    } cell_cfg_t;

    // data offered to one element
    typedef struct packed {
        logic combData;  // combinational result of the tile
        logic otherData; // other incoming data from the routing fabric
    } cell_data_t;

    // controls shared by both elements of a tile
    typedef struct packed {
        logic trigger;     // shared trigger input
        logic gateEnable;  // shared active-high enable
        logic forceInit;   // set/reset input of the tile
        logic globalForce; // chip-wide force to initial values
    } tile_ctrl_t;

    // state held by one element
    typedef struct packed {
        logic prevTrigger; // effective trigger seen on the previous clock
        logic stored;      // value of the storage element
    } cell_state_t;

endpackage : tile_storage_pkg

/* logic/storage_cell.sv */
// one storage element of the logic tile: flip-flop or latch with initial value
`timescale 1ns/1ns
`default_nettype none

module storage_cell
    import tile_storage_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire cell_cfg_t cfg,
    input wire tile_ctrl_t ctrl,
    input wire cell_data_t din,
    output logic stored
);

    // complete state of the element
    cell_state_t state;
    cell_state_t next_state;

    // effective trigger after this element's own inversion
    logic effTrigger;
    // active edge of the effective trigger
    logic activeEdge;
    // enable as seen by this element
    logic effEnable;
    // value offered for capture
    logic captureData;
    // configured initial value
    logic initValue;

    // decode of the element's inputs
    always_comb begin
        effTrigger = ctrl.trigger ^ cfg.invertTrigger; // [RULE3]
        activeEdge = effTrigger & ~state.prevTrigger; // [RULE1]
        effEnable = ctrl.gateEnable | cfg.enableTied; // [RULE4] [RULE5] [RULE7]
        captureData = cfg.captureOther ? din.otherData : din.combData; // [RULE2]
        initValue = cfg.initSet; // [RULE10]
    end

    // next state of the element
    always_comb begin
        next_state = state;
        next_state.prevTrigger = effTrigger;
        if (ctrl.globalForce || ctrl.forceInit) begin
            // force wins over trigger, enable and data
            next_state.stored = initValue; // [RULE8]
        end else if (cfg.latchMode) begin
            // transparent while the effective trigger is low
            if (effEnable && !effTrigger) begin
                next_state.stored = captureData; // [RULE9]
            end
        end else if (effEnable && activeEdge) begin
            // flip-flop loads on the active edge only
            next_state.stored = captureData; // [RULE4]
        end
    end

    // state register; power-up loads the configured initial value
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state.prevTrigger <= 1'b0;
            state.stored <= cfg.initSet; // [RULE8]
        end else begin
            state <= next_state;
        end
    end

    // stored value leaves straight from the flip-flop
    assign stored = state.stored;

endmodule : storage_cell

`default_nettype wire

/* tb/user_fabric.sv */
// model of the user logic that pulses the shared trigger through the fabric
`timescale 1ns/1ns
`default_nettype none
module user_fabric (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic fire,
    input wire logic level,
    output var logic trigger
);
    // one-cycle pulse per request, low at least a cycle between pulses
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            trigger <= 1'b0;
        end else begin
            trigger <= (fire && !trigger) || level;
        end
    end
endmodule : user_fabric
`default_nettype wire

/* tb/tile_storage_props.sv */
// checker of the storage pair: init loads, captures, holds, latch and bus idle data
`timescale 1ns/1ns
`default_nettype none
module tile_storage_props
    import tile_storage_pkg::*;
#(
    parameter int NUM_ELEMENTS = ELEMENT_COUNT
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic trigger,
    input wire logic gateEnable,
    input wire logic forceInit,
    input wire logic globalForce,
    input wire logic [NUM_ELEMENTS-1:0] combData,
    input wire logic [NUM_ELEMENTS-1:0] otherData,
    input wire logic [NUM_ELEMENTS-1:0] storedOut,
    input wire logic [NUM_ELEMENTS-1:0] tileOut
);
    logic wrPend; // config write in its data phase
    logic rdPend; // read in its data phase
    logic [31:0] cfg; // shadow of the config register
    logic take; // address phase accepted
    logic frc; // any force to initial value
    logic en0; // element 0 enable after the tie option
    logic eff0; // element 0 effective trigger
    logic eff1; // element 1 effective trigger
    logic dat0; // element 0 selected data
    logic dat1; // element 1 selected data
    assign take = hsel && hready && htrans == HTRANS_NONSEQ;
    assign frc = forceInit || globalForce;
    assign en0 = gateEnable || cfg[1];
    assign eff0 = trigger ^ cfg[0];
    assign eff1 = trigger ^ cfg[8];
    assign dat0 = cfg[4] ? otherData[0] : combData[0];
    assign dat1 = cfg[12] ? otherData[1] : combData[1];
    // track bus phases and mirror config writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            cfg <= CONFIG_RESET;
        end else begin
            wrPend <= take && hwrite && haddr[7:0] == CONFIG_OFFSET[7:0];
            rdPend <= take && !hwrite;
            if (wrPend) begin
                cfg <= hwdata;
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    force_load_a: assert property (frc |=> storedOut[0] == $past(cfg[2]))
        else $error("initial value not loaded");
    enable_hold_a: assert property (!frc && !en0 |=> $stable(storedOut[0]))
        else $error("disabled element changed");
    edge_capture_a: assert property (!frc && !cfg[3] && en0 && eff0 && !$past(eff0)
        |=> storedOut[0] == $past(dat0)) else $error("element 0 missed its edge");
    invert_capture_a: assert property (!frc && !cfg[11] && (gateEnable || cfg[9])
        && eff1 && !$past(eff1) |=> storedOut[1] == $past(dat1))
        else $error("element 1 missed its edge");
    latch_pass_a: assert property (!frc && cfg[3] && en0 && !eff0
        |=> storedOut[0] == $past(dat0)) else $error("open latch not following");
    latch_hold_a: assert property (!frc && cfg[3] && eff0 |=> $stable(storedOut[0]))
        else $error("closed latch changed");
    comb_route_a: assert property (!cfg[5] |=> tileOut[0] == $past(combData[0]))
        else $error("tile output not the comb result");
    rdata_idle_a: assert property (!rdPend |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus slave waited or answered an error");
endmodule : tile_storage_props
bind logic_tile_storage_pair tile_storage_props #(.NUM_ELEMENTS(NUM_ELEMENTS))
    i_tile_storage_props (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trigger(trigger),
    .gateEnable(gateEnable), .forceInit(forceInit), .globalForce(globalForce),
    .combData(combData), .otherData(otherData), .storedOut(storedOut), .tileOut(tileOut));
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the storage pair over its bus and tile pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_top
    import tile_storage_pkg::*;
;
    logic ref_clk = 1'b0; // bench clock
    logic reset = 1'b1; // synchronous reset
    logic hsel = 1'b0; // bus select
    logic hwrite = 1'b0; // bus direction
    logic [1:0] htrans = 2'h0; // bus transfer type
    logic [31:0] haddr = 32'h0; // bus address
    logic [31:0] hwdata = 32'h0; // bus write data
    logic gateEnable = 1'b0; // shared enable
    logic forceInit = 1'b0; // tile set/reset
    logic globalForce = 1'b0; // chip-wide force
    logic fire = 1'b0; // trigger pulse request
    logic level = 1'b0; // trigger held high
    logic [1:0] combData = 2'h0; // comb results
    logic [1:0] otherData = 2'h0; // other data
    logic trigger, hreadyout, hresp; // design and partner outputs
    logic [31:0] hrdata, rd; // read data and last value read
    logic [1:0] storedOut, tileOut; // element outputs
    int n_errors = 0; // mismatches
    int samples_checked = 0; // comparisons
    always #2 ref_clk = ~ref_clk;
    logic_tile_storage_pair i_logic_tile_storage_pair (.ref_clk(ref_clk), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .trigger(trigger), .gateEnable(gateEnable), .forceInit(forceInit),
        .globalForce(globalForce), .combData(combData), .otherData(otherData),
        .storedOut(storedOut), .tileOut(tileOut));
    user_fabric i_user_fabric (.ref_clk(ref_clk), .reset(reset), .fire(fire), .level(level),
        .trigger(trigger));
    // one single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        // address phase stands until ready is seen high; only the watchdog ends a wait
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= data;
        // data phase stands until ready again; read data is taken at that same edge
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // one trigger pulse, then time for capture and tile output
    task automatic pulse();
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : pulse
    // counts and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    // watchdog against a hang
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        stop_test();
    end
    // test sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        bus(1'b0, CONFIG_OFFSET, 32'h0);
        `CHK("config reset", 32'h0, rd)
        bus(1'b1, CONFIG_OFFSET, 32'hffff_ffff);
        bus(1'b0, CONFIG_OFFSET, 32'h0);
        `CHK("config readback", 32'h0000_3f3f, rd)
        bus(1'b1, CONFIG_OFFSET, 32'h0);
        bus(1'b1, 32'h0000_0010, 32'hffff_ffff);
        bus(1'b0, 32'h0000_0010, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        $display("test registers done");
        gateEnable <= 1'b1;
        combData <= 2'b01;
        otherData <= 2'b10;
        pulse();
        `CHK("edge capture", 2'b01, storedOut)
        @(posedge ref_clk);
        gateEnable <= 1'b0;
        combData <= 2'b10;
        pulse();
        `CHK("enable low hold", 2'b01, storedOut)
        @(posedge ref_clk);
        bus(1'b1, CONFIG_OFFSET, 32'h0000_0002);
        pulse();
        `CHK("tied enable", 2'b00, storedOut)
        @(posedge ref_clk);
        bus(1'b1, CONFIG_OFFSET, 32'h0000_0100);
        // turning the inversion on is itself an edge; let it pass while disabled
        @(posedge ref_clk);
        gateEnable <= 1'b1;
        combData <= 2'b11;
        level <= 1'b1;
        pulse();
        `CHK("rising only", 2'b01, storedOut)
        @(posedge ref_clk);
        level <= 1'b0;
        pulse();
        `CHK("falling edge", 2'b11, storedOut)
        @(posedge ref_clk);
        $display("test flip-flop done");
        bus(1'b1, CONFIG_OFFSET, 32'h0000_3030);
        combData <= 2'b01;
        pulse();
        `CHK("other data", 2'b10, storedOut)
        `CHK("stored routed", 2'b10, tileOut)
        @(posedge ref_clk);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        `CHK("status", 32'h0000_0300, rd)
        bus(1'b1, CONFIG_OFFSET, 32'h0000_0004);
        forceInit <= 1'b1;
        combData <= 2'b10;
        pulse();
        `CHK("set/reset load", 2'b01, storedOut)
        @(posedge ref_clk);
        forceInit <= 1'b0;
        bus(1'b1, CONFIG_OFFSET, 32'h0000_0400);
        globalForce <= 1'b1;
        combData <= 2'b01;
        pulse();
        `CHK("global force", 2'b10, storedOut)
        @(posedge ref_clk);
        globalForce <= 1'b0;
        $display("test routing and force done");
        bus(1'b1, CONFIG_OFFSET, 32'h0000_0808);
        combData <= 2'b01;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("latch open", 2'b01, storedOut)
        @(posedge ref_clk);
        level <= 1'b1;
        repeat (2) @(posedge ref_clk);
        combData <= 2'b10;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("latch closed", 2'b01, storedOut)
        `CHK("comb routed", 2'b10, tileOut)
        @(posedge ref_clk);
        level <= 1'b0;
        $display("test latch done");
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
